// File: hw/irq_ctl_pkg.sv
// Contract
// - four request inputs, level 3 highest priority, level 0 lowest
// - pending requests arbitrated by priority, each level has a mask bit
// - each request input responds to a level or an edge
// - acknowledge jumps to vector 0000 to 0003 matching the level
// - with nesting on, higher level preempts a running lower service
// - reset initialises state clock, stack, cache monitor, mask, mode status
// - during reset with no bus request, program address shows 0004
// - halt input stops execution at end of current instruction
// - before halting, next instruction is fetched externally despite cache
// - while halted, all outputs stay static at state 8 values; here CYCLE_STATE first runs states 1 to 8 once more, then freezes
// - release of halt resumes execution where it stopped
// - trap instruction raises trap output and stops, frozen at state 8
// - while trapped, program address shows address after the trap
// - trap output held until halt seen, then dropped; stopped until release
// - reset release starts state 5 on that same clock edge
// - sensitivity bit 0 selects level, 1 selects edge; undefined at reset
// - service entry masks equal and lower levels if nesting, else all
// - mask bits are positive sense and zero after reset
// - cycle is eight states; 1 to 7 active, state 8 is halt point
package irq_ctl_pkg;
  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [3:0]  ADDR_CTRL     = 4'h0;
  localparam logic [3:0]  ADDR_MASK     = 4'h4;
  localparam logic [3:0]  ADDR_CFG      = 4'h8;
  localparam logic [3:0]  ADDR_STATUS   = 4'hC;
  localparam int          CTRL_TRAP     = 0;
  localparam int          CTRL_RTI      = 1;
  localparam int          CFG_NEST      = 4;
  localparam logic [3:0]  MASK_RESET    = 4'h0;
  localparam logic [3:0]  MODE_STATUS_REG_RESET   = 4'h0;
  localparam logic [13:0] PMA_RESET     = 14'h0004;
  localparam logic [13:0] VEC_BASE      = 14'h0000;
  localparam logic [2:0]  ST_FIRST      = 3'h4;
  localparam logic [2:0]  ST_LAST       = 3'h7;
  localparam int          NLEV          = 4;
  typedef enum logic [1:0] {
    RUN  = 2'b00,
    HALT = 2'b01,
    TRAP = 2'b11
  } run_t;
endpackage

// File: hw/irq_arbiter.sv
`timescale 1ns/1ps
module irq_arbiter (
  input  wire logic [3:0] req,
  input  wire logic [3:0] en,
  output logic            hit,
  output logic [1:0]      lev
);
  wire [3:0] live = req & en;
  // fixed priority, level 3 first
  assign hit = |live;
  assign lev = live[3] ? 2'h3 : live[2] ? 2'h2 : live[1] ? 2'h1 : 2'h0;
endmodule

// File: hw/irq_ctl.sv
`timescale 1ns/1ps
module irq_ctl (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic [3:0]  IRQ_N,
  input  wire logic        HALT_IN,
  input  wire logic        EXTERNAL_BUS_REQUEST_N,
  input  wire logic        INSTR_DONE,
  input  wire logic        CACHE_HIT,
  input  wire logic [13:0] NEXT_PC,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic [13:0]      PROGRAM_ADDRESS_BUS,
  output logic             FORCE_FETCH,
  output logic             TRAP_OUT,
  output logic             STOPPED,
  output logic [2:0]       CYCLE_STATE,
  output logic             VEC_TAKE,
  output logic [13:0]      VEC_ADDR,
  output logic [3:0]       MODE_STATUS,
  output logic             STACK_CLR,
  output logic             CACHE_MON_CLR
);
  // ****************************************
  // state clock: eight states, index 0 = state 1, index 7 = state 8
  // ****************************************
  logic [2:0] st_r;
  logic       stop;
  logic       ack_hit;
  logic [1:0] ack_lev;
  logic       ack_take;
  wire        boundary = (st_r == irq_ctl_pkg::ST_LAST) & INSTR_DONE;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      st_r <= irq_ctl_pkg::ST_FIRST;
    end else if (!stop) begin
      st_r <= st_r + 3'h1;
    end
  end
  assign CYCLE_STATE = st_r;

  // ****************************************
  // registers
  // ****************************************
  logic [3:0] interrupt_enable_bits_r;
  logic [4:0] interrupt_config_bits_r;
  logic [3:0] mode_status_reg_r;
  logic [3:0] edge_lat_r;
  logic [3:0] irq_q_r;
  logic [3:0] in_svc_r;
  logic [3:0] save_mask_r;
  logic       trap_req_r;
  logic       ack_r;
  logic [31:0] rdata_r;
  wire        wr = AVS_WRITE & ~AVS_WAITREQUEST;
  wire        rd = AVS_READ & ~AVS_WAITREQUEST;
  wire        wr_ctrl = wr & (AVS_ADDRESS == irq_ctl_pkg::ADDR_CTRL);
  wire        wr_mask = wr & (AVS_ADDRESS == irq_ctl_pkg::ADDR_MASK);
  wire        wr_cfg  = wr & (AVS_ADDRESS == irq_ctl_pkg::ADDR_CFG);
  wire        rti     = wr_ctrl & AVS_WRITEDATA[irq_ctl_pkg::CTRL_RTI];
  wire        do_trap = wr_ctrl & AVS_WRITEDATA[irq_ctl_pkg::CTRL_TRAP];

  // ****************************************
  // request detection
  // ****************************************
  wire [3:0] irq = ~IRQ_N;
  wire [3:0] pend;
  wire [3:0] edge_clr;
  genvar g;
  generate
    for (g = 0; g < irq_ctl_pkg::NLEV; g++) begin : g_lev
      // 0 = level, 1 = edge
      assign pend[g] = interrupt_config_bits_r[g] ? edge_lat_r[g] : irq[g];
      assign edge_clr[g] = ack_take & (ack_lev == 2'(g));
      // latch only in edge mode, so a level-mode history leaves no stale edge
      always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
          edge_lat_r[g] <= 1'b0;
        end else if (irq[g] & ~irq_q_r[g] & interrupt_config_bits_r[g]) begin
          edge_lat_r[g] <= 1'b1;
        end else if (edge_clr[g] | ~interrupt_config_bits_r[g]) begin
          edge_lat_r[g] <= 1'b0;
        end
      end
    end
  endgenerate
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) irq_q_r <= 4'h0;
    else irq_q_r <= irq;
  end

  // ****************************************
  // arbitration and vectoring
  // ****************************************
  irq_arbiter u_arb (
    .req (pend),
    .en  (interrupt_enable_bits_r),
    .hit (ack_hit),
    .lev (ack_lev)
  );
  assign ack_take = boundary & ack_hit & ~stop & ~HALT_IN;
  wire [3:0] lev_bit = 4'h1 << ack_lev;
  // nesting keeps only strictly higher levels enabled
  wire [3:0] hi_only = ~((lev_bit << 1) - 4'h1);
  wire [3:0] mask_entry = interrupt_config_bits_r[irq_ctl_pkg::CFG_NEST]
                          ? (interrupt_enable_bits_r & hi_only) : 4'h0;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      interrupt_enable_bits_r <= irq_ctl_pkg::MASK_RESET;
      save_mask_r <= irq_ctl_pkg::MASK_RESET;
      in_svc_r <= 4'h0;
    end else if (ack_take) begin
      interrupt_enable_bits_r <= mask_entry;
      save_mask_r <= interrupt_enable_bits_r;
      in_svc_r <= in_svc_r | lev_bit;
    end else if (rti) begin
      // single-depth restore; deeper nests need software to resave
      interrupt_enable_bits_r <= save_mask_r;
      in_svc_r <= 4'h0;
    end else if (wr_mask) begin
      interrupt_enable_bits_r <= AVS_WRITEDATA[3:0];
    end
  end

  // sensitivity and nesting bits have no defined reset value
  always_ff @(posedge CLK_SYS) begin
    if (wr_cfg) interrupt_config_bits_r <= AVS_WRITEDATA[4:0];
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ack_r    <= 1'b0;
      VEC_ADDR <= irq_ctl_pkg::VEC_BASE;
    end else begin
      ack_r <= ack_take;
      if (ack_take) VEC_ADDR <= irq_ctl_pkg::VEC_BASE + {12'h000, ack_lev};
    end
  end
  assign VEC_TAKE = ack_r;

  // ****************************************
  // halt and trap sequencing
  // ****************************************
  irq_ctl_pkg::run_t run_r;
  logic halt_seen_r;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) trap_req_r <= 1'b0;
    else if (do_trap) trap_req_r <= 1'b1;
    else if (boundary) trap_req_r <= 1'b0;
  end
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      run_r <= irq_ctl_pkg::RUN;
      TRAP_OUT <= 1'b0;
    end else begin
      case (run_r)
        irq_ctl_pkg::RUN: begin
          if (boundary & trap_req_r) begin
            run_r <= irq_ctl_pkg::TRAP;
            TRAP_OUT <= 1'b1;
          end else if (boundary & HALT_IN) begin
            run_r <= irq_ctl_pkg::HALT;
          end
        end
        irq_ctl_pkg::TRAP: begin
          if (HALT_IN) begin
            TRAP_OUT <= 1'b0;
            run_r <= irq_ctl_pkg::HALT;
          end
        end
        irq_ctl_pkg::HALT: begin
          if (!HALT_IN) run_r <= irq_ctl_pkg::RUN;
        end
        default: run_r <= irq_ctl_pkg::RUN;
      endcase
    end
  end
  assign stop = (run_r != irq_ctl_pkg::RUN) & (st_r == irq_ctl_pkg::ST_LAST);
  assign STOPPED = run_r != irq_ctl_pkg::RUN;
  // a pending halt forces the next fetch off-chip even on a cache hit
  assign FORCE_FETCH = (HALT_IN | trap_req_r) & CACHE_HIT & ~STOPPED;

  // ****************************************
  // program address and mode status
  // ****************************************
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      PROGRAM_ADDRESS_BUS <= irq_ctl_pkg::PMA_RESET;
      mode_status_reg_r <= irq_ctl_pkg::MODE_STATUS_REG_RESET;
      STACK_CLR <= 1'b1;
      CACHE_MON_CLR <= 1'b1;
    end else begin
      STACK_CLR <= 1'b0;
      CACHE_MON_CLR <= 1'b0;
      if (!STOPPED) PROGRAM_ADDRESS_BUS <= NEXT_PC;
    end
  end
  assign MODE_STATUS = mode_status_reg_r;

  // ****************************************
  // avalon slave, zero wait
  // ****************************************
  assign AVS_WAITREQUEST = 1'b0;
  wire [31:0] rd_mux =
    (AVS_ADDRESS == irq_ctl_pkg::ADDR_MASK) ? {28'h0, interrupt_enable_bits_r} :
    (AVS_ADDRESS == irq_ctl_pkg::ADDR_CFG) ? {27'h0, interrupt_config_bits_r} :
    (AVS_ADDRESS == irq_ctl_pkg::ADDR_STATUS) ?
      {20'h0, in_svc_r, pend, 1'b0, TRAP_OUT, run_r} : 32'h0;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) rdata_r <= 32'h0;
    else if (rd) rdata_r <= rd_mux;
  end
  assign AVS_READDATA = rd ? rd_mux : rdata_r;

  // ****************************************
  // checks
  // ****************************************
  trap_hold_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    TRAP_OUT & ~HALT_IN |=> TRAP_OUT) else $error("trap dropped early");
  trap_drop_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    TRAP_OUT & HALT_IN |=> ~TRAP_OUT) else $error("trap not dropped");
  halt_freeze_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    STOPPED & $past(STOPPED) |-> $stable(PROGRAM_ADDRESS_BUS))
    else $error("address moved while stopped");
  vec_level_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    ack_take |=> VEC_TAKE && VEC_ADDR == {12'h0, $past(ack_lev)})
    else $error("bad vector");
  nest_mask_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    ack_take & ~interrupt_config_bits_r[4] |=> interrupt_enable_bits_r == 4'h0)
    else $error("mask not cleared on entry");
  prio_top_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    ack_take & pend[3] & interrupt_enable_bits_r[3] |-> ack_lev == 2'h3)
    else $error("priority wrong");
  halt_stop_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    boundary & HALT_IN & ~STOPPED |=> STOPPED) else $error("no halt");
  resume_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    run_r == irq_ctl_pkg::HALT & ~HALT_IN |=> ~STOPPED)
    else $error("no resume");
  cv_ack_c: cover property (@(posedge CLK_SYS) ack_take);
  cv_trap_c: cover property (@(posedge CLK_SYS) TRAP_OUT ##[1:20] ~TRAP_OUT);
  cv_halt_c: cover property (@(posedge CLK_SYS) STOPPED ##1 ~STOPPED);
endmodule

// File: tb/ctl_model.sv
`timescale 1ns/1ps
module ctl_model (
  input  wire logic       clk,
  input  wire logic       trap_seen,
  input  wire logic       halt_req,
  input  wire logic [3:0] irq_req,
  input  wire logic [7:0] trap_delay,
  input  wire logic [7:0] hold_len,
  output logic            halt_out,
  output logic [3:0]      irq_n
);
  logic [7:0] cnt_r = 8'h0;
  logic       trap_halt_r = 1'b0;
  // ****
  // controller answer to a trap
  // ****
  // a slow controller notices late, and keeps halt up a while after
  // the trap output falls, so a stop that ends early is seen
  always @(posedge clk) begin
    if (trap_seen && !trap_halt_r) begin
      cnt_r <= cnt_r + 8'h1;
      if (cnt_r >= trap_delay) begin
        trap_halt_r <= 1'b1;
        cnt_r <= 8'h0;
      end
    end else if (trap_halt_r && !trap_seen) begin
      cnt_r <= cnt_r + 8'h1;
      if (cnt_r >= hold_len) trap_halt_r <= 1'b0;
    end else cnt_r <= 8'h0;
  end
  assign halt_out = halt_req | trap_halt_r;
  assign irq_n = ~irq_req;
endmodule

// File: tb/interrupt_halt_trap_control_tb_top.sv
`timescale 1ns/1ps
module interrupt_halt_trap_control_tb_top;
  logic CLK_SYS, RST, HALT_IN, INSTR_DONE, CACHE_HIT, AVS_READ, AVS_WRITE;
  logic EXTERNAL_BUS_REQUEST_N, AVS_WAITREQUEST, FORCE_FETCH, TRAP_OUT;
  logic STOPPED, VEC_TAKE, STACK_CLR, CACHE_MON_CLR, halt_req, pc_hold;
  logic [3:0] IRQ_N, AVS_ADDRESS, MODE_STATUS, irq_req, m, r;
  logic [13:0] NEXT_PC, PROGRAM_ADDRESS_BUS, VEC_ADDR, pab;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, q;
  logic [2:0] CYCLE_STATE;
  logic [7:0] trap_dly, hold_len;
  logic [15:0] lf;
  logic ff_seen;
  int bad_count, check_count, lev;
  int exp_q[$];
  irq_ctl dut_u (.CLK_SYS, .RST, .IRQ_N, .HALT_IN, .EXTERNAL_BUS_REQUEST_N,
    .INSTR_DONE, .CACHE_HIT, .NEXT_PC, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST, .PROGRAM_ADDRESS_BUS,
    .FORCE_FETCH, .TRAP_OUT, .STOPPED, .CYCLE_STATE, .VEC_TAKE, .VEC_ADDR,
    .MODE_STATUS, .STACK_CLR, .CACHE_MON_CLR);
  ctl_model far_u (.clk(CLK_SYS), .trap_seen(TRAP_OUT), .halt_req(halt_req),
    .irq_req(irq_req), .trap_delay(trap_dly), .hold_len(hold_len),
    .halt_out(HALT_IN), .irq_n(IRQ_N));
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end
  // cache hits forced on while stopping, to exercise the forced fetch
  always @(posedge CLK_SYS) begin
    lf <= lfsr_next(lf);
    INSTR_DONE <= lf[0] | lf[1];
    CACHE_HIT <= lf[2] | pc_hold;
    if (!pc_hold) NEXT_PC <= lf[13:0];
  end
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_addr(input logic [13:0] g, input logic [13:0] e);
    chk_word({18'h0, g}, {18'h0, e});
  endtask
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge CLK_SYS);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= ~w;
    do begin
      @(posedge CLK_SYS);
      k++;
    end while (AVS_WAITREQUEST !== 1'b0 && k < 100);
    rd = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask
  function automatic logic cond(input int s);
    case (s)
      0: return VEC_TAKE === 1'b1;
      1: return STOPPED === 1'b1;
      2: return STOPPED === 1'b0;
      3: return TRAP_OUT === 1'b1;
      default: return TRAP_OUT === 1'b0;
    endcase
  endfunction
  task automatic wt(input int s);
    int k;
    k = 0;
    ff_seen = 1'b0;
    do begin
      @(negedge CLK_SYS);
      ff_seen |= FORCE_FETCH === 1'b1;
      k++;
    end while (!cond(s) && k < 400);
    chk_addr({13'h0, cond(s)}, 14'h1);
    @(posedge CLK_SYS);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge CLK_SYS);
    bad_count++;
    stop_test();
  end
  initial begin
    RST = 1'b1;
    lf = 16'h4455;
    {halt_req, pc_hold, irq_req, INSTR_DONE, CACHE_HIT} = 8'h0;
    {trap_dly, hold_len, NEXT_PC} = 30'h0;
    EXTERNAL_BUS_REQUEST_N = 1'b1;
    {AVS_ADDRESS, AVS_READ, AVS_WRITE, AVS_WRITEDATA} = 38'h0;
    repeat (6) @(posedge CLK_SYS);
    chk_addr(PROGRAM_ADDRESS_BUS, irq_ctl_pkg::PMA_RESET);
    chk_addr({11'h0, CYCLE_STATE}, {11'h0, irq_ctl_pkg::ST_FIRST});
    chk_addr({12'h0, STACK_CLR, CACHE_MON_CLR}, 14'h3);
    chk_addr({10'h0, MODE_STATUS}, 14'h0);
    RST <= 1'b0;
    @(negedge CLK_SYS);
    chk_addr({11'h0, CYCLE_STATE}, {11'h0, irq_ctl_pkg::ST_FIRST});
    @(negedge CLK_SYS);
    chk_addr({11'h0, CYCLE_STATE}, 14'h5);
    bus(1'b0, irq_ctl_pkg::ADDR_MASK, 32'h0, q);
    chk_word(q, 32'h0);
    bus(1'b1, 4'h2, 32'hFFFFFFFF, q);
    bus(1'b0, 4'h2, 32'h0, q);
    chk_word(q, 32'h0);
    $display("reset and register test done");
    pc_hold <= 1'b1;
    halt_req <= 1'b1;
    wt(1);
    chk_addr({13'h0, ff_seen}, 14'h1);
    pab = PROGRAM_ADDRESS_BUS;
    repeat (20) @(posedge CLK_SYS);
    chk_addr(PROGRAM_ADDRESS_BUS, pab);
    chk_addr({11'h0, CYCLE_STATE}, {11'h0, irq_ctl_pkg::ST_LAST});
    halt_req <= 1'b0;
    wt(2);
    $display("halt test done");
    for (int i = 0; i < 2; i++) begin
      trap_dly <= i ? 8'h28 : 8'h2;
      hold_len <= 8'h5;
      bus(1'b1, irq_ctl_pkg::ADDR_CTRL, 32'h1, q);
      wt(3);
      wt(1);
      if (i) chk_addr({13'h0, TRAP_OUT}, 14'h1);
      chk_addr(PROGRAM_ADDRESS_BUS, NEXT_PC);
      wt(4);
      chk_addr({13'h0, STOPPED}, 14'h1);
      wt(2);
    end
    pc_hold <= 1'b0;
    $display("trap test done");
    for (int i = 0; i < 8; i++) begin
      m = lf[3:0];
      r = i[0] ? 4'h1 << lf[9:8] : lf[7:4];
      if (r == 4'h0) r = 4'h8;
      if ((m & r) == 4'h0) m = m | r;
      lev = 3;
      while (!(m[lev] && r[lev])) lev--;
      exp_q.push_back(lev);
      bus(1'b1, irq_ctl_pkg::ADDR_CFG, i[0] ? 32'hF : 32'h0, q);
      bus(1'b1, irq_ctl_pkg::ADDR_MASK, {28'h0, m}, q);
      irq_req <= r;
      if (i[0]) @(posedge CLK_SYS) irq_req <= 4'h0;
      wt(0);
      chk_addr(VEC_ADDR, 14'(exp_q.pop_front()));
      irq_req <= 4'h0;
      bus(1'b0, irq_ctl_pkg::ADDR_MASK, 32'h0, q);
      chk_word(q, 32'h0);
      bus(1'b1, irq_ctl_pkg::ADDR_CTRL, 32'h2, q);
    end
    $display("priority test done");
    bus(1'b1, irq_ctl_pkg::ADDR_CFG, 32'h10, q);
    bus(1'b1, irq_ctl_pkg::ADDR_MASK, 32'hF, q);
    irq_req <= 4'h1;
    wt(0);
    chk_addr(VEC_ADDR, irq_ctl_pkg::VEC_BASE);
    bus(1'b0, irq_ctl_pkg::ADDR_MASK, 32'h0, q);
    chk_word(q, 32'hE);
    irq_req <= 4'h5;
    wt(0);
    chk_addr(VEC_ADDR, 14'h2);
    irq_req <= 4'h0;
    $display("nesting test done");
    stop_test();
  end
endmodule
